// >>> inc/gpmux_pkg.sv
// Function
// - eight pins, each pin's direction set on its own
// - reset leaves pins as port with input, output, pull-up off
// - three function selects; all zero means port, a one picks function
// - interrupt input passes whenever input enabled, outside stop mode
// - registers decoded at fixed offsets from the port base
// - data holds eight read-write bits; bits 31-8 read zero
// - output control bit enables pin driver; resets to zero
// - select a bits 6-0 route pins to bus address 23-17; bit 7 zero
// - select b routes serial clock, rx, tx, timer captures; irq five passes whatever select b holds
// - select c bit 7 clock out, bit 6 clear-to-send; 3-0 read zero
// - driver type bit: zero push-pull, one open-drain
// - pull-up bit one enables the pin's pull-up
// - input control bit one enables the pin's input buffer
`default_nettype none
package gpmux_pkg;
  localparam int gpmux_pins = 8;
  localparam logic [5:0] gpmux_off_data = 6'h00;
  localparam logic [5:0] gpmux_off_oe = 6'h04;
  localparam logic [5:0] gpmux_off_fsa = 6'h08;
  localparam logic [5:0] gpmux_off_fsb = 6'h0c;
  localparam logic [5:0] gpmux_off_fsc = 6'h10;
  localparam logic [5:0] gpmux_off_od = 6'h28;
  localparam logic [5:0] gpmux_off_pup = 6'h2c;
  localparam logic [5:0] gpmux_off_ie = 6'h38;
  localparam logic [7:0] gpmux_rst_val = 8'h00;
  localparam logic [7:0] gpmux_fsa_mask = 8'h7f;
  localparam logic [7:0] gpmux_fsc_mask = 8'hf0;
  localparam logic [1:0] gpmux_resp_okay = 2'b00;
  localparam logic [1:0] gpmux_resp_slverr = 2'b10;
  localparam int gpmux_bit_irq = 7;
  localparam int gpmux_bit_sclk = 6;
  localparam int gpmux_bit_rxd = 5;
  localparam int gpmux_bit_txd = 4;
  localparam int gpmux_bit_clkout = 7;
  localparam int gpmux_bit_cts = 6;
endpackage : gpmux_pkg
`default_nettype wire

// >>> hw/gpmux_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module gpmux_pin_cell (
  input wire logic is_port,
  input wire logic port_data,
  input wire logic port_oe,
  input wire logic alt_drive,
  input wire logic alt_data,
  input wire logic open_drain,
  input wire logic in_en,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic in_value
);
  logic drv;
  logic val;
  always_comb begin
    drv = is_port ? port_oe : alt_drive;
    val = is_port ? port_data : alt_data;
    pin_out = open_drain ? 1'b0 : val;
    pin_oe = drv & (open_drain ? ~val : 1'b1);
    in_value = in_en & pin_in;
  end
endmodule : gpmux_pin_cell
`default_nettype wire

// >>> hw/gpmux_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module gpmux_axil_slave
  import gpmux_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [5:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_hit,
  output logic [5:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);
  logic aw_full;
  logic w_full;
  logic [5:0] aw_q;
  logic [7:0] w_q;
  logic w_lane;
  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  assign s_awready = ~aw_full & ~s_bvalid;
  assign s_wready = ~w_full & ~s_bvalid;
  assign wr_en = aw_full & w_full & ~s_bvalid & w_lane;
  assign wr_addr = aw_q;
  assign wr_data = w_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_q <= 6'h00;
      w_q <= 8'h00;
      w_lane <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= gpmux_resp_okay;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full <= 1'b1;
        aw_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_full <= 1'b1;
        w_q <= s_wdata[7:0];
        w_lane <= s_wstrb[0];
      end
      if (aw_full && w_full && !s_bvalid) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? gpmux_resp_okay : gpmux_resp_slverr;
        aw_full <= 1'b0;
        w_full <= 1'b0;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign s_arready = ~s_rvalid;
  assign rd_addr = s_araddr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= gpmux_resp_okay;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= {24'h00_0000, rd_data};
      s_rresp <= rd_hit ? gpmux_resp_okay : gpmux_resp_slverr;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule : gpmux_axil_slave
`default_nettype wire

// >>> hw/gpmux_port.sv
`timescale 1ns/1ps
`default_nettype none
module gpmux_port
  import gpmux_pkg::*;
#(
  parameter int pins = gpmux_pins
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [5:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  input wire logic stop_mode,
  input wire logic [6:0] bus_address_top,
  input wire logic bus_address_drive,
  input wire logic serial_clock_line,
  input wire logic serial_clock_drive,
  input wire logic serial_transmit_line,
  input wire logic system_clock_output,
  output logic serial_clock_in,
  output logic serial_receive_line,
  output logic serial_clear_to_send,
  output logic external_irq_line_five,
  output logic [7:0] pin_irq,
  output logic timer_five_capture_a,
  output logic timer_five_capture_b,
  output logic timer_six_capture_a,
  output logic timer_six_capture_b
);
  logic [7:0] port_pin_data;
  logic [7:0] port_output_enable;
  logic [7:0] port_function_select_a;
  logic [7:0] port_function_select_b;
  logic [7:0] port_function_select_c;
  logic [7:0] port_driver_type;
  logic [7:0] port_pullup_enable;
  logic [7:0] port_input_enable;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_hit;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_hit;
  logic [7:0] is_port;
  logic [7:0] alt_drive;
  logic [7:0] alt_data;
  logic [7:0] in_value;

  // elaboration check: pin count is fixed by the register layout
  if (pins != 8) begin : g_bad_pins
    $error("gpmux_port supports exactly eight pins");
  end

  function automatic logic known_offset(input logic [5:0] a);
    case (a)
      gpmux_off_data, gpmux_off_oe, gpmux_off_fsa, gpmux_off_fsb,
      gpmux_off_fsc, gpmux_off_od, gpmux_off_pup, gpmux_off_ie:
        known_offset = 1'b1;
      default: known_offset = 1'b0;
    endcase
  endfunction : known_offset

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  gpmux_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  assign wr_hit = known_offset(wr_addr);
  assign rd_hit = known_offset(rd_addr);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_pin_data <= gpmux_rst_val;
      port_output_enable <= gpmux_rst_val;
      port_function_select_a <= gpmux_rst_val;
      port_function_select_b <= gpmux_rst_val;
      port_function_select_c <= gpmux_rst_val;
      port_driver_type <= gpmux_rst_val;
      port_pullup_enable <= gpmux_rst_val;
      port_input_enable <= gpmux_rst_val;
    end else if (wr_en) begin
      case (wr_addr)
        gpmux_off_data: port_pin_data <= wr_data;
        gpmux_off_oe: port_output_enable <= wr_data;
        gpmux_off_fsa:
          port_function_select_a <= wr_data & gpmux_fsa_mask;
        gpmux_off_fsb: port_function_select_b <= wr_data;
        gpmux_off_fsc:
          port_function_select_c <= wr_data & gpmux_fsc_mask;
        gpmux_off_od: port_driver_type <= wr_data;
        gpmux_off_pup: port_pullup_enable <= wr_data;
        gpmux_off_ie: port_input_enable <= wr_data;
        default: port_pin_data <= port_pin_data;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (rd_addr)
      gpmux_off_data:
        rd_data = (port_pin_data & ~port_input_enable) | in_value;
      gpmux_off_oe: rd_data = port_output_enable;
      gpmux_off_fsa: rd_data = port_function_select_a;
      gpmux_off_fsb: rd_data = port_function_select_b;
      gpmux_off_fsc: rd_data = port_function_select_c;
      gpmux_off_od: rd_data = port_driver_type;
      gpmux_off_pup: rd_data = port_pullup_enable;
      gpmux_off_ie: rd_data = port_input_enable;
      default: rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // function routing
  // ---------------------------------------------------------------
  // software keeps selects exclusive; on overlap c overrides b, and b overrides a
  always_comb begin
    is_port = ~(port_function_select_a | port_function_select_b |
      port_function_select_c);
    alt_drive = 8'h00;
    alt_data = 8'h00;
    alt_drive[6:0] = {7{bus_address_drive}};
    alt_data[6:0] = bus_address_top;
    if (port_function_select_b[gpmux_bit_sclk]) begin
      alt_drive[6] = serial_clock_drive;
      alt_data[6] = serial_clock_line;
    end
    if (port_function_select_b[gpmux_bit_txd]) begin
      alt_drive[4] = 1'b1;
      alt_data[4] = serial_transmit_line;
    end
    if (port_function_select_b[gpmux_bit_rxd]) begin
      alt_drive[5] = 1'b0;
    end
    if (port_function_select_b[3:0] != 4'h0) begin
      alt_drive[3:0] = alt_drive[3:0] & ~port_function_select_b[3:0];
    end
    if (port_function_select_c[gpmux_bit_clkout]) begin
      alt_drive[7] = 1'b1;
      alt_data[7] = system_clock_output;
    end
    if (port_function_select_c[gpmux_bit_cts]) begin
      alt_drive[6] = 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      gpmux_pin_cell u_cell (
        .is_port(is_port[i]),
        .port_data(port_pin_data[i]),
        .port_oe(port_output_enable[i]),
        .alt_drive(alt_drive[i]),
        .alt_data(alt_data[i]),
        .open_drain(port_driver_type[i]),
        .in_en(port_input_enable[i]),
        .pin_in(pin_in[i]),
        .pin_out(pin_out[i]),
        .pin_oe(pin_oe[i]),
        .in_value(in_value[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // alternate inputs
  // ---------------------------------------------------------------
  always_comb begin
    pin_pullup = port_pullup_enable;
    pin_irq = stop_mode ? 8'h00 : in_value;
    external_irq_line_five = ~stop_mode & in_value[gpmux_bit_irq];
    serial_clock_in = port_function_select_b[gpmux_bit_sclk] & in_value[6];
    serial_receive_line =
      port_function_select_b[gpmux_bit_rxd] & in_value[5];
    serial_clear_to_send =
      port_function_select_c[gpmux_bit_cts] & in_value[6];
    timer_five_capture_a = port_function_select_b[0] & in_value[0];
    timer_five_capture_b = port_function_select_b[1] & in_value[1];
    timer_six_capture_a = port_function_select_b[2] & in_value[2];
    timer_six_capture_b = port_function_select_b[3] & in_value[3];
  end
endmodule : gpmux_port
`default_nettype wire

// >>> tb/gpmux_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gpmux_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [1:0] s_bresp,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_irq,
  input wire logic stop_mode,
  input wire logic external_irq_line_five
);
  // ----
  // port checks
  // ----
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_reset_idle: assert property (
    !$past(aresetn) |-> pin_oe == 8'h00 && pin_pullup == 8'h00)
    else $error("pins active after reset");
  chk_stop_irq: assert property (
    stop_mode |-> pin_irq == 8'h00 && !external_irq_line_five)
    else $error("irq passed in stop mode");
  chk_write_answer: assert property (
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("no write response");
  chk_read_answer: assert property (
    s_arvalid && s_arready |=> s_rvalid)
    else $error("no read response");
  chk_bresp_hold: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  chk_upper_zero: assert property (
    s_rvalid |-> s_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_aw_refused: assert property (
    s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while response pending");
  chk_irq_five: assert property (
    external_irq_line_five |-> pin_irq[7])
    else $error("irq five without enabled input");
  cover property (s_bvalid && s_bready);
  cover property (s_rvalid && s_rready);
  cover property (external_irq_line_five);
  cover property (s_bvalid && !s_bready);
endmodule : gpmux_chk
bind gpmux_port gpmux_chk chk_i (.aclk, .aresetn, .s_awvalid, .s_awready,
  .s_wvalid, .s_wready, .s_bvalid, .s_bready, .s_bresp, .s_arvalid,
  .s_arready, .s_rvalid, .s_rready, .s_rdata, .pin_oe, .pin_pullup,
  .pin_irq, .stop_mode, .external_irq_line_five);
`default_nettype wire

// >>> tb/gpmux_board.sv
`timescale 1ns/1ps
`default_nettype none
module gpmux_board (
  input wire logic aclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] board_oe,
  input wire logic [7:0] board_val,
  output logic [7:0] pin_in
);
  // ----
  // pin level resolution
  // ----
  logic [7:0] float_pat = 8'h55;
  always @(posedge aclk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (board_oe[i]) pin_in[i] = board_val[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_pat[i];
    end
  end
endmodule : gpmux_board
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import gpmux_pkg::*;
;
  logic aclk, aresetn, stop_mode, bus_address_drive, serial_transmit_line;
  logic system_clock_output, s_awvalid, s_wvalid, s_bready, s_arvalid;
  logic s_rready, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic serial_clock_in, serial_receive_line, serial_clear_to_send;
  logic external_irq_line_five, timer_five_capture_a, timer_five_capture_b;
  logic timer_six_capture_a, timer_six_capture_b;
  logic serial_clock_line, serial_clock_drive;
  logic [3:0] s_wstrb;
  logic [5:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0] s_bresp, s_rresp;
  logic [6:0] bus_address_top;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, pin_irq;
  logic [7:0] board_oe, board_val;
  int error_cnt, total_checks;
  logic [5:0] offs [8] = '{gpmux_off_data, gpmux_off_oe, gpmux_off_fsa,
    gpmux_off_fsb, gpmux_off_fsc, gpmux_off_od, gpmux_off_pup, gpmux_off_ie};
  logic [7:0] wv [8] = '{8'h5a, 8'h0f, 8'h83, 8'h0c, 8'hc0, 8'h01,
    8'h3c, 8'h00};
  logic [7:0] ev [8] = '{8'h5a, 8'h0f, 8'h03, 8'h0c, 8'hc0, 8'h01,
    8'h3c, 8'h00};
  gpmux_port uut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .stop_mode, .bus_address_top, .bus_address_drive,
    .serial_clock_line, .serial_clock_drive,
    .serial_transmit_line, .system_clock_output, .serial_clock_in,
    .serial_receive_line, .serial_clear_to_send, .external_irq_line_five,
    .pin_irq, .timer_five_capture_a, .timer_five_capture_b,
    .timer_six_capture_a, .timer_six_capture_b);
  gpmux_board board (.aclk, .pin_out, .pin_oe, .pin_pullup, .board_oe,
    .board_val, .pin_in);
  // ----
  // tasks
  // ----
  task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : ck
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
    input logic [1:0] er = gpmux_resp_okay, input int dly = 0);
    s_awaddr <= a;
    s_wdata <= {24'h00_0000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= (dly == 0);
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
    repeat (dly) @(posedge aclk);
    s_bready <= 1'b1;
    do @(posedge aclk); while (!s_bvalid);
    s_bready <= 1'b0;
    ck("bresp", {6'h00, er}, {6'h00, s_bresp});
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e,
    input logic [1:0] er = gpmux_resp_okay, input int dly = 0);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= (dly == 0);
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    repeat (dly) @(posedge aclk);
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_rvalid);
    s_rready <= 1'b0;
    ck("rdata", e, s_rdata[7:0]);
    ck("rdata_hi", 8'h00, {7'h00, |s_rdata[31:8]});
    ck("rresp", {6'h00, er}, {6'h00, s_rresp});
    @(posedge aclk);
  endtask : rd
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // ----
  // tests
  // ----
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    idle(2000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    aresetn = 1'b0;
    {stop_mode, bus_address_drive, serial_transmit_line} = 3'h0;
    {serial_clock_line, serial_clock_drive} = 2'h0;
    s_wstrb = 4'hf;
    {system_clock_output, s_awvalid, s_wvalid, s_bready} = 4'h0;
    {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    {bus_address_top, board_oe, board_val} = '0;
    idle(6);
    aresetn <= 1'b1;
    idle(1);
    for (int i = 0; i < 8; i++) rd(offs[i], 8'h00);
    ck("pin_oe", 8'h00, pin_oe);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      wr(offs[i], wv[i], gpmux_resp_okay, 2);
      rd(offs[i], ev[i], gpmux_resp_okay, 2);
    end
    wr(gpmux_off_fsa, 8'h00);
    wr(gpmux_off_fsb, 8'h00);
    wr(gpmux_off_fsc, 8'h00);
    ck("pin_pullup", 8'h3c, pin_pullup);
    ck("pin_oe", 8'h0f, pin_oe);
    ck("pin_out", 8'h0a, pin_out & 8'h0f);
    wr(gpmux_off_data, 8'h5b);
    ck("od_release", 8'h0e, pin_oe);
    $display("register test done");
    wr(gpmux_off_oe, 8'h00);
    wr(gpmux_off_ie, 8'hff);
    board_oe <= 8'hff;
    board_val <= 8'ha5;
    idle(3);
    rd(gpmux_off_data, 8'ha5);
    ck("pin_irq", 8'ha5, pin_irq);
    stop_mode <= 1'b1;
    idle(3);
    ck("stop_irq", 8'h00, pin_irq);
    stop_mode <= 1'b0;
    $display("input test done");
    serial_transmit_line <= 1'b1;
    {serial_clock_line, serial_clock_drive} <= 2'h3;
    wr(gpmux_off_fsb, 8'hff);
    idle(3);
    ck("alt_in", 8'h35, {2'h0, external_irq_line_five, serial_receive_line,
      timer_six_capture_b, timer_six_capture_a, timer_five_capture_b,
      timer_five_capture_a});
    ck("txd", 8'h01, {7'h00, pin_out[4]});
    ck("sclk", 8'h03, {6'h00, pin_out[6], serial_clock_in});
    wr(gpmux_off_fsb, 8'h00);
    bus_address_top <= 7'h35;
    bus_address_drive <= 1'b1;
    wr(gpmux_off_od, 8'h00);
    wr(gpmux_off_fsa, 8'h7f);
    ck("bus_addr", 8'h35, {1'b0, pin_out[6:0]});
    ck("bus_oe", 8'h7f, {1'b0, pin_oe[6:0]});
    wr(gpmux_off_fsa, 8'h00);
    board_val <= 8'h40;
    system_clock_output <= 1'b1;
    wr(gpmux_off_fsc, 8'hc0);
    idle(3);
    ck("fsc", 8'h03, {6'h00, pin_out[7], serial_clear_to_send});
    $display("function test done");
    wr(6'h14, 8'hff, gpmux_resp_slverr);
    rd(6'h14, 8'h00, gpmux_resp_slverr);
    s_wstrb <= 4'h0;
    wr(gpmux_off_pup, 8'hff);
    s_wstrb <= 4'hf;
    rd(gpmux_off_pup, 8'h3c);
    $display("unmapped test done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
